/* src/acc_pkg.sv */
// How it works
// - Clearing start bit aborts the running conversion.
// - Restart always starts the newly written channel; a core done in the cycle after the write completes it with the old data.
// - Four modes; single modes convert selected channel, scan counts down from it to 0.
// - Writing 80h starts single channel conversion.
// - Every completion sets the done flag.
// - Done flag drives interrupt or transfer request.
// - Unread result at completion sets overrun flag.
// - Overrun stays correct for reads near completion.
// - Scan results carry channel in top nibble.
package acc_pkg;

  // Register byte offsets
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 4'hC;

  // Control register fields
  localparam int CHAN_W = 4;
  localparam int CTL_CHAN_LSB = 0;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_START_BIT = 7;
  localparam int CTL_XFER_BIT = 8;
  localparam logic [7:0] CTRL_SINGLE_START = 8'h80;

  // Result word layout
  localparam int RES_W = 16;
  localparam int RES_TAG_LSB = 12;

  // Status and mask bit positions
  localparam int ST_W = 2;
  localparam int ST_DONE = 0;
  localparam int ST_OVR = 1;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing windows in converter clock units
  localparam int RESTART_WIN_TCL = 2;
  localparam int OVR_WIN_TCL = 6;

  // Conversion modes, code 0 is single channel
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_SINGLE_CONT,
    MODE_SCAN,
    MODE_SCAN_CONT
  } acc_mode_t;

  // Controller states
  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } acc_fsm_t;

  // Commands to the analog core
  typedef struct packed {
    logic start;
    logic abort;
    logic [CHAN_W-1:0] chan;
  } acc_core_req_t;

  // Answer from the analog core
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } acc_core_rsp_t;

endpackage

/* src/acc_top.sv */
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module acc_top #(
  parameter int DATA_W = 10
) (
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  input wire logic [acc_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [acc_pkg::ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output acc_pkg::acc_core_req_t O_CORE,
  input wire acc_pkg::acc_core_rsp_t I_CORE,
  output logic O_XFER_REQ,
  input wire logic I_XFER_ACK,
  output logic [acc_pkg::RES_W-1:0] O_XFER_DATA,
  output logic O_IRQ
);
  import acc_pkg::*;

  // Refuse result widths that collide with the channel tag
  if (DATA_W < 1 || DATA_W > RES_TAG_LSB) begin : g_chk
    $error("DATA_W must be 1 to 12");
  end

  // Whole module state
  typedef struct packed {
    acc_fsm_t fsm;
    logic [CHAN_W-1:0] chan_sel; // Channel written by software
    acc_mode_t mode; // Selected mode
    logic start; // Conversion start bit
    logic xfer_sel; // Done goes to transfer instead of interrupt
    logic [CHAN_W-1:0] cur_chan; // Channel under conversion
    logic [RES_W-1:0] result; // Last result word
    logic unread; // Result not yet fetched
    logic [ST_W-1:0] status; // Sticky event flags
    logic [ST_W-1:0] mask; // Interrupt enables
    logic aw_hold; // Write address captured
    logic [ADDR_W-1:0] aw_addr;
    logic w_hold; // Write data captured
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic core_start; // One cycle start pulse
    logic core_abort; // One cycle abort pulse
  } acc_state_t;

  acc_state_t s_r;
  acc_state_t s_nxt;

  // Event terms shared by logic and checks
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_fire;
  logic wr_ctrl;
  logic done_evt;
  logic rd_clr;
  logic ovr_evt;
  logic [CHAN_W-1:0] wr_chan;
  logic wr_start;
  logic scan_mode;

  // Read mux and address check
  function automatic logic [33:0] reg_read(input logic [ADDR_W-1:0] addr, input acc_state_t s);
    logic [31:0] d;
    logic [1:0] r;
    d = '0;
    r = RESP_OKAY;
    unique case (addr)
      ADDR_CTRL: begin
        d[CTL_CHAN_LSB +: CHAN_W] = s.chan_sel;
        d[CTL_MODE_LSB +: 2] = s.mode;
        d[CTL_START_BIT] = s.start;
        d[CTL_XFER_BIT] = s.xfer_sel;
      end
      ADDR_RESULT: d[RES_W-1:0] = s.result;
      ADDR_STATUS: d[ST_W-1:0] = s.status;
      ADDR_MASK: d[ST_W-1:0] = s.mask;
      default: r = RESP_SLVERR; // Unmapped reads zero with error
    endcase
    return {r, d};
  endfunction

  // Handshakes and events
  assign O_AWREADY = !s_r.aw_hold && !s_r.bvalid;
  assign O_WREADY = !s_r.w_hold && !s_r.bvalid;
  assign O_ARREADY = !s_r.rvalid;
  assign aw_fire = I_AWVALID && O_AWREADY;
  assign w_fire = I_WVALID && O_WREADY;
  assign ar_fire = I_ARVALID && O_ARREADY;
  assign wr_fire = s_r.aw_hold && s_r.w_hold && !s_r.bvalid;
  assign wr_ctrl = wr_fire && s_r.aw_addr == ADDR_CTRL && s_r.wstrb[0];
  assign wr_chan = s_r.wdata[CTL_CHAN_LSB +: CHAN_W];
  assign wr_start = s_r.wdata[CTL_START_BIT];
  assign done_evt = I_CORE.done && s_r.fsm == ST_CONV;
  assign scan_mode = s_r.mode == MODE_SCAN || s_r.mode == MODE_SCAN_CONT;
  // Fetch by bus or by transfer; it sees the old word
  assign rd_clr = (ar_fire && I_ARADDR == ADDR_RESULT) || (I_XFER_ACK && O_XFER_REQ);
  assign ovr_evt = done_evt && s_r.unread && !rd_clr;

  // Next state
  always_comb begin
    logic [ST_W-1:0] set_v;
    logic [ST_W-1:0] clr_v;
    set_v = '0;
    clr_v = '0;
    s_nxt = s_r;
    s_nxt.core_start = 1'b0;
    s_nxt.core_abort = 1'b0;

    // Capture write address and data in any order
    if (aw_fire) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_addr = I_AWADDR;
    end
    if (w_fire) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.wdata = I_WDATA;
      s_nxt.wstrb = I_WSTRB;
    end
    // Response retires on bready
    if (s_r.bvalid && I_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end

    // Read channel
    if (s_r.rvalid && I_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_fire) begin
      {s_nxt.rresp, s_nxt.rdata} = reg_read(I_ARADDR, s_r);
      s_nxt.rvalid = 1'b1;
    end

    // Completion of a conversion
    if (done_evt) begin
      s_nxt.result = '0;
      s_nxt.result[DATA_W-1:0] = I_CORE.data[DATA_W-1:0];
      if (scan_mode) begin
        s_nxt.result[RES_TAG_LSB +: CHAN_W] = s_r.cur_chan;
      end
      set_v[ST_DONE] = 1'b1;
      set_v[ST_OVR] = ovr_evt;
      unique case (s_r.mode)
        MODE_SINGLE: begin
          s_nxt.start = 1'b0;
          s_nxt.fsm = ST_IDLE;
        end
        MODE_SINGLE_CONT: begin
          s_nxt.core_start = 1'b1;
        end
        MODE_SCAN, MODE_SCAN_CONT: begin
          if (s_r.cur_chan != '0) begin
            s_nxt.cur_chan = s_r.cur_chan - 1'b1;
            s_nxt.core_start = 1'b1;
          end else if (s_r.mode == MODE_SCAN_CONT) begin
            s_nxt.cur_chan = s_r.chan_sel;
            s_nxt.core_start = 1'b1;
          end else begin
            s_nxt.start = 1'b0;
            s_nxt.fsm = ST_IDLE;
          end
        end
      endcase
    end

    // Unread tracking, a new result wins over a fetch
    if (done_evt) begin
      s_nxt.unread = 1'b1;
    end else if (rd_clr) begin
      s_nxt.unread = 1'b0;
    end
    if (I_XFER_ACK && O_XFER_REQ) begin
      clr_v[ST_DONE] = 1'b1;
    end

    // Register write, a control write overrides the completion step
    if (wr_fire) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case (s_r.aw_addr)
        ADDR_CTRL: begin
          if (s_r.wstrb[0]) begin
            s_nxt.chan_sel = wr_chan;
            s_nxt.mode = acc_mode_t'(s_r.wdata[CTL_MODE_LSB +: 2]);
            s_nxt.start = wr_start;
            if (wr_start) begin
              // Fresh start always takes the written channel
              s_nxt.cur_chan = wr_chan;
              s_nxt.fsm = ST_CONV;
              s_nxt.core_start = 1'b1;
              s_nxt.core_abort = s_r.fsm == ST_CONV && !done_evt;
            end else begin
              // Start bit cleared stops the conversion
              s_nxt.fsm = ST_IDLE;
              s_nxt.core_start = 1'b0;
              s_nxt.core_abort = s_r.fsm == ST_CONV && !done_evt;
            end
          end
          if (s_r.wstrb[1]) begin
            s_nxt.xfer_sel = s_r.wdata[CTL_XFER_BIT];
          end
        end
        ADDR_STATUS: begin
          if (s_r.wstrb[0]) begin
            clr_v = clr_v | s_r.wdata[ST_W-1:0];
          end
        end
        ADDR_MASK: begin
          if (s_r.wstrb[0]) begin
            s_nxt.mask = s_r.wdata[ST_W-1:0];
          end
        end
        ADDR_RESULT: begin
          s_nxt.bresp = RESP_SLVERR; // Result is read only
        end
        default: s_nxt.bresp = RESP_SLVERR; // Unmapped write
      endcase
    end

    // Sticky flags, set wins over clear
    s_nxt.status = (s_r.status & ~clr_v) | set_v;
  end

  // State register
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs from state
  assign O_BVALID = s_r.bvalid;
  assign O_BRESP = s_r.bresp;
  assign O_RVALID = s_r.rvalid;
  assign O_RRESP = s_r.rresp;
  assign O_RDATA = s_r.rdata;
  assign O_CORE.start = s_r.core_start;
  assign O_CORE.abort = s_r.core_abort;
  assign O_CORE.chan = s_r.cur_chan;
  assign O_XFER_DATA = s_r.result;
  // Done routed to transfer request or interrupt
  assign O_XFER_REQ = s_r.xfer_sel && s_r.status[ST_DONE];
  assign O_IRQ = (s_r.status[ST_DONE] && s_r.mask[ST_DONE] && !s_r.xfer_sel) ||
                 (s_r.status[ST_OVR] && s_r.mask[ST_OVR]);

  // Checks
  localparam int OVR_WIN = OVR_WIN_TCL;
  localparam int RESTART_WIN = RESTART_WIN_TCL; // Restart hazard span after a completion

  sequence seq_missed;
    ovr_evt;
  endsequence

  sequence seq_late_fetch;
    ##[1:OVR_WIN] rd_clr;
  endsequence

  chk_stop_on_clear: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    wr_ctrl && !wr_start && s_r.fsm == ST_CONV && !done_evt |=> s_r.fsm == ST_IDLE && s_r.core_abort && !s_r.start)
    else $error("clearing start did not stop conversion");

  chk_restart_chan: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    wr_ctrl && wr_start |=> s_r.core_start && O_CORE.chan == $past(wr_chan) && s_r.fsm == ST_CONV)
    else $error("restart did not use the written channel");

  chk_scan_step: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    done_evt && scan_mode && s_r.cur_chan != '0 && !wr_ctrl |=>
      s_r.core_start && s_r.cur_chan == $past(s_r.cur_chan) - 1'b1)
    else $error("scan did not step to next channel");

  chk_write_80: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    wr_ctrl && s_r.wdata[7:0] == CTRL_SINGLE_START |=> s_r.mode == MODE_SINGLE && s_r.start && s_r.core_start)
    else $error("80h did not start single conversion");

  chk_done_flag: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    done_evt |=> s_r.status[ST_DONE] && s_r.unread)
    else $error("completion did not set done flag");

  chk_route_done: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    s_r.status[ST_DONE] |-> (s_r.xfer_sel ? O_XFER_REQ : (O_IRQ == s_r.mask[ST_DONE] || s_r.status[ST_OVR])))
    else $error("done flag not routed");

  chk_overrun_set: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    done_evt && s_r.unread && !rd_clr |=> s_r.status[ST_OVR])
    else $error("missed result did not raise overrun");

  chk_late_read: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    seq_missed ##0 seq_late_fetch |=> s_r.status[ST_OVR] || $past(wr_fire))
    else $error("late fetch hid overrun");

  chk_same_read: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    done_evt && rd_clr && !s_r.status[ST_OVR] && !wr_fire |=> !s_r.status[ST_OVR] && s_r.unread)
    else $error("fetch at completion raised false overrun");

  chk_scan_tag: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    done_evt && scan_mode |=> s_r.result[RES_TAG_LSB +: CHAN_W] == $past(s_r.cur_chan))
    else $error("scan result lacks channel tag");

  chk_single_clear: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    done_evt && s_r.mode == MODE_SINGLE && !wr_ctrl |=> !s_r.start && s_r.fsm == ST_IDLE && !s_r.core_start)
    else $error("single mode kept start bit");

  chk_cont_keep: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    done_evt && s_r.mode == MODE_SINGLE_CONT && !wr_ctrl |=> s_r.start && s_r.core_start)
    else $error("continuous mode dropped start bit");

  // Fresh start written close behind a completion
  sequence seq_start_near_done;
    done_evt ##[0:RESTART_WIN] (wr_ctrl && wr_start);
  endsequence

  chk_restart_window: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    seq_start_near_done |=> s_r.core_start && O_CORE.chan == $past(wr_chan))
    else $error("restart near completion skipped the written channel");

  chk_ovr_sticky: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    s_r.status[ST_OVR] && !(wr_fire && s_r.aw_addr == ADDR_STATUS) |=> s_r.status[ST_OVR])
    else $error("overrun flag dropped without a clear");

  chk_fetch_clears: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    rd_clr && !done_evt |=> !s_r.unread)
    else $error("fetch left result marked unread");

  chk_xfer_ack: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    I_XFER_ACK && O_XFER_REQ && !done_evt |=> !O_XFER_REQ)
    else $error("transfer fetch did not retire request");

endmodule

/* tb/acc_core_model.sv */
`timescale 1ns/10ps
// Analog core stand-in: fixed conversion time, data tagged by channel
module acc_core_model #(
  parameter int DELAY = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire acc_pkg::acc_core_req_t i_req,
  output acc_pkg::acc_core_rsp_t o_rsp
);
  import acc_pkg::*;
  logic busy_r; // Conversion running
  int cnt_r; // Cycles left
  logic [3:0] chan_r; // Channel being converted
  logic [11:0] last_r; // Last result, inverted between pulses
  // Start wins over abort so a restart keeps running
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_r <= 1'b0;
      cnt_r <= 0;
      chan_r <= 4'h0;
      last_r <= 12'h000;
      o_rsp <= '0;
    end else begin
      o_rsp.done <= 1'b0;
      o_rsp.data <= ~last_r;
      if (i_req.start) begin
        busy_r <= 1'b1;
        cnt_r <= DELAY;
        chan_r <= i_req.chan;
      end else if (i_req.abort) begin
        busy_r <= 1'b0;
      end else if (busy_r && cnt_r == 1) begin
        busy_r <= 1'b0;
        o_rsp.done <= 1'b1;
        o_rsp.data <= {8'h5A, chan_r};
        last_r <= {8'h5A, chan_r};
      end else if (busy_r) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule

/* tb/tb_adc_conversion_control.sv */
`timescale 1ns/10ps
module tb_adc_conversion_control;
  import acc_pkg::*;
  logic I_CLOCK, I_NRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_XFER_ACK;
  logic [ADDR_W-1:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA, O_RDATA, rd_d;
  logic [3:0] I_WSTRB;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_XFER_REQ, O_IRQ;
  logic [1:0] O_BRESP, O_RRESP, rsp;
  acc_core_req_t O_CORE;
  acc_core_rsp_t I_CORE;
  logic [RES_W-1:0] O_XFER_DATA;
  int miscompares = 0;
  int n_tests = 0;
  acc_top #(.DATA_W(10)) u_dut (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_AWADDR(I_AWADDR),
    .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB),
    .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .O_CORE(O_CORE), .I_CORE(I_CORE), .O_XFER_REQ(O_XFER_REQ), .I_XFER_ACK(I_XFER_ACK),
    .O_XFER_DATA(O_XFER_DATA), .O_IRQ(O_IRQ));
  acc_core_model #(.DELAY(8)) u_core (.i_clk(I_CLOCK), .i_nrst(I_NRST), .i_req(O_CORE), .o_rsp(I_CORE));
  // Clock at 40 MHz
  initial begin
    I_CLOCK = 1'b0;
    forever #12.5 I_CLOCK = ~I_CLOCK;
  end
  // Expected result word for a channel, tag only in scan modes
  function automatic logic [31:0] res(input logic [3:0] c, input logic tag);
    return {16'h0000, (tag ? c : 4'h0), 2'b00, 10'h1A0 | {6'h00, c}};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: hold each channel until its ready is seen at an edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, b;
    ta = 1'b0;
    tw = 1'b0;
    b = 1'b0;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge I_CLOCK);
      if (O_AWREADY) ta = 1'b1;
      if (O_WREADY) tw = 1'b1;
      @(posedge I_CLOCK);
      if (ta) I_AWVALID <= 1'b0;
      if (tw) I_WVALID <= 1'b0;
    end
    while (!b) begin
      @(negedge I_CLOCK);
      b = O_BVALID;
      rsp = O_BRESP;
      @(posedge I_CLOCK);
    end
    // Bready stays high so back to back writes never toggle it in one step
  endtask
  task automatic rd(input logic [3:0] a);
    logic t;
    t = 1'b0;
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    while (!t) begin
      @(negedge I_CLOCK);
      t = O_ARREADY;
      @(posedge I_CLOCK);
    end
    I_ARVALID <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge I_CLOCK);
      t = O_RVALID;
      rd_d = O_RDATA;
      rsp = O_RRESP;
      @(posedge I_CLOCK);
    end
    // Rready stays high so back to back reads never toggle it in one step
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_d, exp);
  endtask
  // Poll status until the done flag shows
  task automatic wait_done();
    rd_d = 32'h0;
    for (int i = 0; i < 30 && !rd_d[ST_DONE]; i++) rd(ADDR_STATUS);
  endtask
  task automatic irqc(input logic [31:0] exp);
    @(negedge I_CLOCK);
    chk(32'(O_IRQ), exp);
    @(posedge I_CLOCK);
  endtask
  task automatic t_single();
    wr(ADDR_CTRL, 32'h80);
    // Fetch lands on the completion edge and must see the old word
    repeat (8) @(posedge I_CLOCK);
    rdc(ADDR_RESULT, 32'h0);
    rdc(ADDR_STATUS, 32'h1);
    rdc(ADDR_CTRL, 32'h0);
    rdc(ADDR_RESULT, res(4'h0, 1'b0));
    $display("single conversion test done");
  endtask
  task automatic t_overrun();
    wr(ADDR_MASK, 32'h3);
    wr(ADDR_STATUS, 32'h3);
    wr(ADDR_CTRL, 32'h81);
    wait_done();
    wr(ADDR_CTRL, 32'h81);
    // Late fetch just after completion gets the new word, overrun still raised
    @(negedge I_CLOCK);
    while (!I_CORE.done) @(negedge I_CLOCK);
    @(posedge I_CLOCK);
    rdc(ADDR_RESULT, res(4'h1, 1'b0));
    rdc(ADDR_STATUS, 32'h3);
    irqc(32'h1);
    wr(ADDR_MASK, 32'h0);
    irqc(32'h0);
    wr(ADDR_MASK, 32'h3);
    wr(ADDR_STATUS, 32'h3);
    irqc(32'h0);
    rdc(ADDR_RESULT, res(4'h1, 1'b0));
    $display("overrun and interrupt test done");
  endtask
  // Scan from channel 2 with results fetched by the transfer port
  task automatic t_scan();
    wr(ADDR_CTRL, 32'h1A2);
    for (int c = 2; c >= 0; c--) begin
      @(negedge I_CLOCK);
      while (!O_XFER_REQ) @(negedge I_CLOCK);
      chk({16'h0000, O_XFER_DATA}, res(4'(c), 1'b1));
      @(posedge I_CLOCK);
      I_XFER_ACK <= 1'b1;
      @(posedge I_CLOCK);
      I_XFER_ACK <= 1'b0;
    end
    rdc(ADDR_CTRL, 32'h122);
    wr(ADDR_CTRL, 32'h0);
    $display("scan transfer test done");
  endtask
  task automatic t_abort();
    wr(ADDR_CTRL, 32'h93);
    wr(ADDR_CTRL, 32'h13);
    wr(ADDR_STATUS, 32'h3);
    repeat (20) @(posedge I_CLOCK);
    rdc(ADDR_STATUS, 32'h0);
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_CTRL, 32'h80);
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_CTRL, 32'hB5);
    @(negedge I_CLOCK);
    chk(32'(O_CORE.chan), 32'h5);
    while (!I_CORE.done) @(negedge I_CLOCK);
    @(posedge I_CLOCK);
    rdc(ADDR_RESULT, res(4'h5, 1'b1));
    wr(ADDR_CTRL, 32'hB6);
    @(negedge I_CLOCK);
    chk(32'(O_CORE.chan), 32'h6);
    @(posedge I_CLOCK);
    wr(ADDR_CTRL, 32'h0);
    $display("abort and restart test done");
  endtask
  task automatic t_bus();
    wr(ADDR_RESULT, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    rdc(4'h6, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    $display("bus error test done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {I_NRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_XFER_ACK} = '0;
    {I_AWADDR, I_ARADDR, I_WDATA} = '0;
    I_WSTRB = 4'hF;
    repeat (2) @(posedge I_CLOCK);
    I_NRST <= 1'b1;
    @(posedge I_CLOCK);
    t_single();
    t_overrun();
    t_scan();
    t_abort();
    t_bus();
    end_of_test();
  end
endmodule
